// [verilog/echo_adapt_tone_ctrl.sv]
// per-channel adaptation control, non-linear processor control and disable tone detection
// Overview of operation
// - double-talk when send exceeds receive plus threshold
// - uncertain periods slow adaptation, zero slow halts
// - double-talk threshold defaults to 0.5625 guardband
// - threshold register sixteen bits, fraction times 32768
// - fast reconvergence only with path detect enabled
// - path clear zeroes coefficients on major change
// - residual below threshold gets extra 30 dB
// - comfort noise injected while processor active
// - disable bits turn off processor or noise
// - processor type select, advanced by default
// - ramp scheme bit sets ramp rate direction
// - ramp and scaling defaults depend on processor
// - comfort noise level rises with scaling value
// - advanced safeguards keep echo, double-talk out
// - reversal mode: one second, one reversal
// - plain mode: tone held 400 ms
// - two detectors per channel, receive and send
// - detection sets status, interrupt on detect/release
// - status holds until both inputs quiet 400 ms
// - tone type select: one plain, zero reversal
// - automatic mode bypasses on detect, returns on release
// - bypass passes codes through and clears filter
`timescale 1ns/1ps
`default_nettype none

module echo_adapt_tone_ctrl #(
	parameter int CHANNELS = 4,
	parameter int PLAIN_TONE_CYCLES = echo_ctrl_pkg::PLAIN_TONE_CYCLES,
	parameter int REVERSAL_TONE_CYCLES = echo_ctrl_pkg::REVERSAL_TONE_CYCLES,
	parameter int RELEASE_CYCLES = echo_ctrl_pkg::RELEASE_CYCLES
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// host configuration, loaded on cfgWrite
	input wire logic cfgWrite,
	input wire logic cfgPreset,
	input wire logic [15:0] cfgDoubleTalkThreshold,
	input wire logic [15:0] cfgSuppressionThreshold,
	input wire logic [2:0] cfgSlowField,
	input wire logic cfgProcessorType,
	input wire logic cfgRejectEcho,
	input wire logic cfgRejectDoubletalk,
	input wire logic cfgRampScheme,
	input wire logic [3:0] cfgRampRate,
	input wire logic [7:0] cfgNoiseScaling,
	input wire logic [CHANNELS-1:0] cfgPathDetect,
	input wire logic [CHANNELS-1:0] cfgPathClear,
	input wire logic [CHANNELS-1:0] cfgProcessorDisable,
	input wire logic [CHANNELS-1:0] cfgNoiseInjectDisable,
	input wire logic [CHANNELS-1:0] cfgToneTypeSelect,
	input wire logic [CHANNELS-1:0] cfgAutoToneDisable,
	// host state control and interrupt service
	input wire logic [CHANNELS-1:0] hostBypass,
	input wire logic [CHANNELS-1:0] hostAdaptDisable,
	input wire logic [CHANNELS-1:0] irqClear,
	// levels and events from the datapath, dBm0
	input wire logic [CHANNELS-1:0][7:0] recvLevel,
	input wire logic [CHANNELS-1:0][7:0] sendLevel,
	input wire logic [CHANNELS-1:0][7:0] errorLevel,
	input wire logic [CHANNELS-1:0] uncertain,
	input wire logic [CHANNELS-1:0] pathChange,
	// tone analysis, index 2c is receive and 2c+1 send
	input wire logic [2*CHANNELS-1:0] toneInBand,
	input wire logic [2*CHANNELS-1:0][7:0] toneLevel,
	input wire logic [2*CHANNELS-1:0] phaseReversal,
	input wire logic [2*CHANNELS-1:0][7:0] lowBandLevel,
	input wire logic [2*CHANNELS-1:0][7:0] highBandLevel,
	// pcm codes
	input wire logic [CHANNELS-1:0][7:0] recvInCode,
	input wire logic [CHANNELS-1:0][7:0] sendInCode,
	input wire logic [CHANNELS-1:0][7:0] cancelledCode,
	output logic [CHANNELS-1:0][7:0] recvOutCode,
	output logic [CHANNELS-1:0][7:0] sendOutCode,
	// filter control
	output logic [CHANNELS-1:0] adaptEnable,
	output logic [CHANNELS-1:0][3:0] adaptShift,
	output logic [CHANNELS-1:0] clearCoeff,
	output logic [CHANNELS-1:0] fastConverge,
	output logic [CHANNELS-1:0] bypassActive,
	output logic [CHANNELS-1:0] doubleTalk,
	// non-linear processor
	output logic [CHANNELS-1:0] nlpActive,
	output logic [CHANNELS-1:0][5:0] extraAttenuation,
	output logic [CHANNELS-1:0] injectNoise,
	output logic [CHANNELS-1:0][7:0] comfortLevel,
	// status and interrupt
	output logic [CHANNELS-1:0] toneDetected,
	output logic irqN
);

	localparam int DETECTORS = 2 * CHANNELS;
	localparam int TW = echo_ctrl_pkg::TIMER_WIDTH;

	// refuse counts the timers cannot hold
	initial begin
		if (CHANNELS < 1 || PLAIN_TONE_CYCLES < 1 || REVERSAL_TONE_CYCLES < 1 ||
				RELEASE_CYCLES < 1 || REVERSAL_TONE_CYCLES >= (1 << TW) ||
				PLAIN_TONE_CYCLES >= (1 << TW) || RELEASE_CYCLES >= (1 << TW)) begin
			$error("echo_adapt_tone_ctrl: unsupported parameter value");
		end
	end

	// fractional Q15 threshold to dB: 6 dB per octave plus a 3-bit mantissa table
	function automatic logic signed [9:0] thresholdToDb(input logic [15:0] thr);
		logic signed [9:0] db;
		logic [15:0] norm;
		logic [3:0] msb;
		db = 10'(echo_ctrl_pkg::LEVEL_FLOOR);
		norm = 16'h0000;
		msb = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (thr[i]) begin
				msb = 4'(i);
			end
		end
		if (thr != 16'h0000) begin
			norm = 16'(thr << (4'hf - msb));
			db = 10'(signed'({6'h00, msb}) - 10'sd15) * signed'({2'b00, echo_ctrl_pkg::DB_PER_OCTAVE});
			case (norm[14:12])
				3'h0: db = db;
				3'h1: db = db + 10'sd1;
				3'h2: db = db + 10'sd2;
				3'h3, 3'h4: db = db + 10'sd3;
				3'h5: db = db + 10'sd4;
				default: db = db + 10'sd5;
			endcase
		end
		return db;
	endfunction

	// sign extension of a dBm0 level for overflow-free sums
	function automatic logic signed [9:0] ext(input logic [7:0] level);
		return signed'({{2{level[7]}}, level});
	endfunction

	// configuration registers
	logic [15:0] doubleTalkThreshold;
	logic [15:0] suppressionThreshold;
	logic [2:0] slowField;
	logic processorTypeSelect;
	logic rejectEchoAsNoise;
	logic rejectDoubletalkAsNoise;
	logic rampSchemeSelect;
	logic [3:0] rampRateField;
	logic [7:0] noiseScaling;
	logic [CHANNELS-1:0] pathDetectEnable;
	logic [CHANNELS-1:0] pathClearEnable;
	logic [CHANNELS-1:0] processorDisable;
	logic [CHANNELS-1:0] noiseInjectDisable;
	logic [CHANNELS-1:0] toneTypeSelect;
	logic [CHANNELS-1:0] autoToneDisable;

	// preset loads the defaults that suit the chosen processor type
	always_ff @(posedge clock) begin
		if (rst) begin
			doubleTalkThreshold <= echo_ctrl_pkg::DOUBLE_TALK_THRESHOLD_RESET;
			suppressionThreshold <= echo_ctrl_pkg::SUPPRESSION_THRESHOLD_RESET;
			slowField <= echo_ctrl_pkg::SLOW_FIELD_RESET;
			processorTypeSelect <= echo_ctrl_pkg::PROCESSOR_TYPE_RESET;
			rejectEchoAsNoise <= echo_ctrl_pkg::REJECT_RESET;
			rejectDoubletalkAsNoise <= echo_ctrl_pkg::REJECT_RESET;
			rampSchemeSelect <= echo_ctrl_pkg::RAMP_SCHEME_RESET;
			rampRateField <= echo_ctrl_pkg::RAMP_RATE_ADVANCED;
			noiseScaling <= echo_ctrl_pkg::NOISE_SCALING_ADVANCED;
			pathDetectEnable <= '0;
			pathClearEnable <= '0;
			processorDisable <= '0;
			noiseInjectDisable <= '0;
			toneTypeSelect <= '0;
			autoToneDisable <= '0;
		end else if (cfgPreset) begin
			processorTypeSelect <= cfgProcessorType;
			rejectEchoAsNoise <= cfgProcessorType;
			rejectDoubletalkAsNoise <= cfgProcessorType;
			rampSchemeSelect <= cfgProcessorType;
			rampRateField <= cfgProcessorType ? echo_ctrl_pkg::RAMP_RATE_ADVANCED :
				echo_ctrl_pkg::RAMP_RATE_ORIGINAL;
			noiseScaling <= cfgProcessorType ? echo_ctrl_pkg::NOISE_SCALING_ADVANCED :
				echo_ctrl_pkg::NOISE_SCALING_ORIGINAL;
		end else if (cfgWrite) begin
			doubleTalkThreshold <= cfgDoubleTalkThreshold;
			suppressionThreshold <= cfgSuppressionThreshold;
			slowField <= cfgSlowField;
			processorTypeSelect <= cfgProcessorType;
			rejectEchoAsNoise <= cfgRejectEcho;
			rejectDoubletalkAsNoise <= cfgRejectDoubletalk;
			rampSchemeSelect <= cfgRampScheme;
			rampRateField <= cfgRampRate;
			noiseScaling <= cfgNoiseScaling;
			pathDetectEnable <= cfgPathDetect;
			pathClearEnable <= cfgPathClear;
			processorDisable <= cfgProcessorDisable;
			noiseInjectDisable <= cfgNoiseInjectDisable;
			toneTypeSelect <= cfgToneTypeSelect;
			autoToneDisable <= cfgAutoToneDisable;
		end
	end

	// threshold offsets in dB, shared by all channels
	wire logic signed [9:0] doubleTalkOffset = thresholdToDb(doubleTalkThreshold);
	wire logic signed [9:0] suppressionOffset = thresholdToDb(suppressionThreshold);
	// original processor has no safeguards, so the reject bits only count when advanced
	wire logic guardEcho = processorTypeSelect & rejectEchoAsNoise;
	wire logic guardDoubletalk = processorTypeSelect & rejectDoubletalkAsNoise;
	// ramp period: scheme 1 faster at low rate, scheme 0 faster at high rate
	// five-bit multiplier so rate f (scheme 1) and rate 0 (scheme 0) do not wrap to zero
	wire logic [12:0] rampPeriod = rampSchemeSelect ?
		{5'({1'b0, rampRateField} + 5'h01), 8'h00} :
		{5'(5'h10 - {1'b0, rampRateField}), 8'h00};
	wire logic signed [9:0] scalingOffset = signed'({5'h00, noiseScaling[7:3]}) - 10'sd8;

	// tone detector states, per detector
	echo_ctrl_pkg::tone_state_e toneState [DETECTORS];
	echo_ctrl_pkg::tone_state_e next_toneState [DETECTORS];
	logic [DETECTORS-1:0] toneHeld;
	logic [DETECTORS-1:0] toneTrigger;
	logic [CHANNELS-1:0] channelRelease;
	logic [CHANNELS-1:0] pending;

	// one tone detector per direction, two per channel
	for (genvar d = 0; d < DETECTORS; d++) begin : g_tone
		logic [TW-1:0] toneTimer;
		logic reversalSeen;
		wire logic plainMode = toneTypeSelect[d/2];
		wire logic signed [9:0] lvl = ext(toneLevel[d]);
		wire logic signed [9:0] levelMax = plainMode ? ext(echo_ctrl_pkg::PLAIN_LEVEL_MAX) :
			ext(echo_ctrl_pkg::REVERSAL_LEVEL_MAX);
		wire logic toneValid = toneInBand[d] && lvl <= levelMax &&
			lvl >= ext(echo_ctrl_pkg::TONE_LEVEL_MIN);
		wire logic plainDone = toneTimer >= TW'(PLAIN_TONE_CYCLES - 1);
		wire logic reversalDone = toneTimer >= TW'(REVERSAL_TONE_CYCLES - 1) &&
			(reversalSeen || phaseReversal[d]);
		assign toneTrigger[d] = toneState[d] == echo_ctrl_pkg::TONE_QUALIFY && toneValid &&
			(plainMode ? plainDone : reversalDone);
		assign toneHeld[d] = toneState[d] == echo_ctrl_pkg::TONE_HELD;

		// a break in the tone restarts qualification
		always_comb begin
			next_toneState[d] = toneState[d];
			case (toneState[d])
				echo_ctrl_pkg::TONE_IDLE: begin
					if (toneValid) begin
						next_toneState[d] = echo_ctrl_pkg::TONE_QUALIFY;
					end
				end
				echo_ctrl_pkg::TONE_QUALIFY: begin
					if (!toneValid) begin
						next_toneState[d] = echo_ctrl_pkg::TONE_IDLE;
					end else if (toneTrigger[d]) begin
						next_toneState[d] = echo_ctrl_pkg::TONE_HELD;
					end
				end
				echo_ctrl_pkg::TONE_HELD: begin
					if (channelRelease[d/2]) begin
						next_toneState[d] = echo_ctrl_pkg::TONE_IDLE;
					end
				end
				default: next_toneState[d] = echo_ctrl_pkg::TONE_IDLE;
			endcase
		end

		// timer counts valid tone cycles in qualify, the first qualify cycle is count zero
		always_ff @(posedge clock) begin
			if (rst) begin
				toneState[d] <= echo_ctrl_pkg::TONE_IDLE;
				toneTimer <= '0;
				reversalSeen <= 1'b0;
			end else begin
				toneState[d] <= next_toneState[d];
				toneTimer <= (next_toneState[d] == echo_ctrl_pkg::TONE_QUALIFY &&
					toneState[d] == echo_ctrl_pkg::TONE_QUALIFY) ? toneTimer + TW'(1) : '0;
				reversalSeen <= next_toneState[d] == echo_ctrl_pkg::TONE_QUALIFY &&
					(reversalSeen || (toneState[d] == echo_ctrl_pkg::TONE_QUALIFY &&
					phaseReversal[d]));
			end
		end
	end

	// per-channel control
	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		logic [TW-1:0] releaseTimer;
		logic [12:0] rampTimer;
		logic signed [9:0] noiseEstimate;
		wire logic statusNow = |toneHeld[2*c+1:2*c];
		// release needs both receive and send quiet in both bands
		wire logic quiet = ext(lowBandLevel[2*c]) < ext(echo_ctrl_pkg::RELEASE_LOW_BAND) &&
			ext(lowBandLevel[2*c+1]) < ext(echo_ctrl_pkg::RELEASE_LOW_BAND) &&
			ext(highBandLevel[2*c]) < ext(echo_ctrl_pkg::RELEASE_HIGH_BAND) &&
			ext(highBandLevel[2*c+1]) < ext(echo_ctrl_pkg::RELEASE_HIGH_BAND);
		assign channelRelease[c] = statusNow && quiet &&
			releaseTimer >= TW'(RELEASE_CYCLES - 1);
		wire logic toneEvent = |toneTrigger[2*c+1:2*c] || channelRelease[c];
		wire logic bypassNow = hostBypass[c] || (autoToneDisable[c] && statusNow);
		wire logic dtNow = ext(sendLevel[c]) > ext(recvLevel[c]) + doubleTalkOffset;
		wire logic slowHalt = uncertain[c] && slowField == 3'h0;
		wire logic majorChange = pathChange[c] && pathDetectEnable[c];
		wire logic nlpEnabled = !processorDisable[c] && !bypassNow;
		wire logic belowSuppression = ext(errorLevel[c]) < ext(recvLevel[c]) + suppressionOffset;
		wire logic nlpNow = nlpEnabled && belowSuppression;
		wire logic injectNow = nlpNow && !noiseInjectDisable[c];
		// safeguards keep double-talk and uncancelled echo out of the estimate
		wire logic estimateFreeze = (guardDoubletalk && dtNow) ||
			(guardEcho && !belowSuppression);
		wire logic rampTick = rampTimer >= rampPeriod - 13'h0001;
		wire logic signed [9:0] comfortSum = noiseEstimate + scalingOffset;

		// release timer runs only while the status is held and both inputs are quiet
		always_ff @(posedge clock) begin
			if (rst || !statusNow || !quiet || channelRelease[c]) begin
				releaseTimer <= '0;
			end else begin
				releaseTimer <= releaseTimer + TW'(1);
			end
		end

		// interrupt flag: a new event in the clearing cycle wins
		always_ff @(posedge clock) begin
			if (rst) begin
				pending[c] <= 1'b0;
			end else if (toneEvent) begin
				pending[c] <= 1'b1;
			end else if (irqClear[c]) begin
				pending[c] <= 1'b0;
			end
		end

		// background noise estimate steps one dB per ramp tick toward the residual
		always_ff @(posedge clock) begin
			if (rst) begin
				rampTimer <= 13'h0000;
				noiseEstimate <= ext(echo_ctrl_pkg::LEVEL_FLOOR);
			end else begin
				rampTimer <= rampTick ? 13'h0000 : rampTimer + 13'h0001;
				if (rampTick && !estimateFreeze) begin
					if (noiseEstimate < ext(errorLevel[c])) begin
						noiseEstimate <= noiseEstimate + 10'sd1;
					end else if (noiseEstimate > ext(errorLevel[c])) begin
						noiseEstimate <= noiseEstimate - 10'sd1;
					end
				end
			end
		end

		// registered channel outputs
		always_ff @(posedge clock) begin
			if (rst) begin
				adaptEnable[c] <= 1'b0;
				adaptShift[c] <= 4'h0;
				clearCoeff[c] <= 1'b0;
				fastConverge[c] <= 1'b0;
				bypassActive[c] <= 1'b0;
				doubleTalk[c] <= 1'b0;
				nlpActive[c] <= 1'b0;
				extraAttenuation[c] <= 6'h00;
				injectNoise[c] <= 1'b0;
				comfortLevel[c] <= 8'h00;
				toneDetected[c] <= 1'b0;
				recvOutCode[c] <= 8'h00;
				sendOutCode[c] <= 8'h00;
			end else begin
				// adaptation halts in bypass, on host disable, double-talk or zero slow field while uncertain
				adaptEnable[c] <= !bypassNow && !hostAdaptDisable[c] && !dtNow && !slowHalt;
				adaptShift[c] <= uncertain[c] ? {1'b0, slowField} : 4'h0;
				clearCoeff[c] <= bypassNow || (majorChange && pathClearEnable[c]);
				fastConverge[c] <= majorChange && !bypassNow;
				bypassActive[c] <= bypassNow;
				doubleTalk[c] <= dtNow;
				nlpActive[c] <= nlpNow;
				extraAttenuation[c] <= nlpNow ? echo_ctrl_pkg::EXTRA_ATTENUATION_DB : 6'h00;
				injectNoise[c] <= injectNow;
				comfortLevel[c] <= injectNow ? comfortSum[7:0] : echo_ctrl_pkg::LEVEL_FLOOR;
				toneDetected[c] <= statusNow;
				recvOutCode[c] <= recvInCode[c];
				sendOutCode[c] <= bypassNow ? sendInCode[c] : cancelledCode[c];
			end
		end
	end

	// single active-low interrupt, registered so it cannot glitch
	always_ff @(posedge clock) begin
		if (rst) begin
			irqN <= 1'b1;
		end else begin
			irqN <= ~|pending;
		end
	end

endmodule

`default_nettype wire

// [verilog/echo_ctrl_pkg.sv]
// constants shared by the echo adaptation and tone control block
package echo_ctrl_pkg;
	// clock and time base
	localparam int CLOCK_HZ = 200_000_000;
	localparam int CYCLES_PER_MS = CLOCK_HZ / 1000;
	localparam int PLAIN_TONE_MS = 400;
	localparam int REVERSAL_TONE_MS = 1000;
	localparam int RELEASE_MS = 400;
	localparam int PLAIN_TONE_CYCLES = PLAIN_TONE_MS * CYCLES_PER_MS;
	localparam int REVERSAL_TONE_CYCLES = REVERSAL_TONE_MS * CYCLES_PER_MS;
	localparam int RELEASE_CYCLES = RELEASE_MS * CYCLES_PER_MS;
	localparam int TIMER_WIDTH = 28;

	// register reset and preset values
	localparam logic [15:0] DOUBLE_TALK_THRESHOLD_RESET = 16'h4800;
	localparam logic [15:0] SUPPRESSION_THRESHOLD_RESET = 16'h2000;
	localparam logic [2:0] SLOW_FIELD_RESET = 3'h4;
	localparam logic PROCESSOR_TYPE_RESET = 1'b1;
	localparam logic REJECT_RESET = 1'b1;
	localparam logic RAMP_SCHEME_RESET = 1'b1;
	localparam logic [3:0] RAMP_RATE_ADVANCED = 4'h5;
	localparam logic [3:0] RAMP_RATE_ORIGINAL = 4'hc;
	localparam logic [7:0] NOISE_SCALING_ADVANCED = 8'h16;
	localparam logic [7:0] NOISE_SCALING_ORIGINAL = 8'h74;

	// levels in dBm0, signed 8 bit; attenuation and octave step in unsigned dB
	localparam logic signed [7:0] PLAIN_LEVEL_MAX = 8'sh00;
	localparam logic signed [7:0] REVERSAL_LEVEL_MAX = -8'sh06;
	localparam logic signed [7:0] TONE_LEVEL_MIN = -8'sh1f;
	localparam logic signed [7:0] RELEASE_LOW_BAND = -8'sh1e;
	localparam logic signed [7:0] RELEASE_HIGH_BAND = -8'sh22;
	localparam logic signed [7:0] LEVEL_FLOOR = -8'sh60;
	localparam logic [5:0] EXTRA_ATTENUATION_DB = 6'h1e;
	localparam logic [7:0] DB_PER_OCTAVE = 8'h06;

	// tone detector states
	typedef enum logic [1:0] {
		TONE_IDLE = 2'b00,
		TONE_QUALIFY = 2'b01,
		TONE_HELD = 2'b10
	} tone_state_e;
endpackage

// [tb/echo_ctrl_assertions.sv]
// concurrent checks on the ports of the echo control block
`timescale 1ns/1ps
`default_nettype none

module echo_ctrl_assertions #(
	parameter int CHANNELS = 4
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// pcm codes
	input wire logic [CHANNELS-1:0][7:0] recvInCode,
	input wire logic [CHANNELS-1:0][7:0] sendInCode,
	input wire logic [CHANNELS-1:0][7:0] recvOutCode,
	input wire logic [CHANNELS-1:0][7:0] sendOutCode,
	// filter and processor control
	input wire logic [CHANNELS-1:0] adaptEnable,
	input wire logic [CHANNELS-1:0] clearCoeff,
	input wire logic [CHANNELS-1:0] bypassActive,
	input wire logic [CHANNELS-1:0] doubleTalk,
	input wire logic [CHANNELS-1:0] nlpActive,
	input wire logic [CHANNELS-1:0][5:0] extraAttenuation,
	// status and interrupt
	input wire logic [CHANNELS-1:0] toneDetected,
	input wire logic irqN
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// detector edges; the first edge after reset is skipped by the pass-through checks
	sequence s_detect;
		$rose(toneDetected[0]);
	endsequence
	sequence s_release;
		$fell(toneDetected[0]);
	endsequence

	a_recv_code_pass: assert property (!$past(rst) |-> recvOutCode == $past(recvInCode))
		else $error("receive code not passed through");
	a_bypass_send_pass: assert property (bypassActive[0] && !$past(rst) |-> sendOutCode[0] == $past(sendInCode[0]))
		else $error("send code not passed in bypass");
	a_bypass_clears_filter: assert property ((bypassActive & ~clearCoeff) == '0)
		else $error("bypass without coefficient clear");
	a_bypass_stops_adapt: assert property ((bypassActive & adaptEnable) == '0)
		else $error("adaptation during bypass");
	a_doubletalk_halts: assert property ((doubleTalk & adaptEnable) == '0)
		else $error("adaptation during double-talk");
	a_extra_atten: assert property (extraAttenuation[0] == (nlpActive[0] ? 6'h1e : 6'h00))
		else $error("wrong extra attenuation");
	a_irq_on_detect: assert property (s_detect |-> ##[0:2] !irqN)
		else $error("no interrupt on detection");
	a_irq_on_release: assert property (s_release |-> ##[0:2] !irqN)
		else $error("no interrupt on release");
	a_status_holds: assert property (s_detect |=> toneDetected[0] [*8])
		else $error("tone status dropped early");
endmodule

bind echo_adapt_tone_ctrl echo_ctrl_assertions #(.CHANNELS(CHANNELS)) checker_inst (.clock,
	.rst, .recvInCode, .sendInCode, .recvOutCode, .sendOutCode, .adaptEnable, .clearCoeff,
	.bypassActive, .doubleTalk, .nlpActive, .extraAttenuation, .toneDetected, .irqN);
`default_nettype wire

// [tb/echo_host_model.sv]
// host controller model that services the tone interrupt
`timescale 1ns/1ps
`default_nettype none

module echo_host_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// service speed and channels left to the device
	input wire logic slow,
	input wire logic [3:0] autoMask,
	// device status
	input wire logic irqN,
	input wire logic [3:0] toneDetected,
	// channel control
	output logic [3:0] hostBypass,
	output logic [3:0] irqClear
);
	logic [3:0] waitCount;

	// a late answer is as legal as a prompt one, so both are offered
	always_ff @(posedge clock) begin
		if (rst) begin
			waitCount <= 4'h0;
			hostBypass <= 4'h0;
			irqClear <= 4'h0;
		end else begin
			irqClear <= 4'h0;
			if (waitCount != 4'h0) begin
				waitCount <= waitCount - 4'h1;
			end else if (!irqN) begin
				waitCount <= slow ? 4'hc : 4'h2;
			end
			if (waitCount == 4'h1) begin
				hostBypass <= toneDetected & ~autoMask;
				irqClear <= 4'hf;
			end
		end
	end
endmodule
`default_nettype wire

// [tb/test_echo_adapt_tone_ctrl.sv]
// self-checking bench for the echo adaptation and tone control block
`timescale 1ns/1ps
`default_nettype none

module test_echo_adapt_tone_ctrl;
	logic clock, rst, cfgWrite, cfgPreset, cfgProcessorType, cfgRampScheme, hostSlow, irqN;
	logic cfgRejectEcho, cfgRejectDoubletalk;
	logic [15:0] cfgDoubleTalkThreshold, cfgSuppressionThreshold;
	logic [2:0] cfgSlowField;
	logic [3:0] cfgRampRate, cfgPathDetect, cfgPathClear, cfgProcessorDisable, cfgNoiseInjectDisable;
	logic [3:0] cfgToneTypeSelect, cfgAutoToneDisable, hostAdaptDisable, uncertain, pathChange;
	logic [3:0] adaptEnable, clearCoeff, fastConverge, bypassActive, doubleTalk, nlpActive;
	logic [3:0] injectNoise, toneDetected;
	logic [7:0] cfgNoiseScaling, toneInBand, phaseReversal, c0;
	logic [3:0][7:0] recvLevel, sendLevel, errorLevel, recvInCode, sendInCode, cancelledCode;
	logic [3:0][7:0] recvOutCode, sendOutCode, comfortLevel;
	logic [7:0][7:0] toneLevel, lowBandLevel, highBandLevel;
	logic [3:0][3:0] adaptShift;
	logic [3:0][5:0] extraAttenuation;
	wire logic [3:0] hostBypass, irqClear;
	int fails, total_checks, n;

	// tone timers shortened so the run stays brief
	echo_adapt_tone_ctrl #(.CHANNELS(4), .PLAIN_TONE_CYCLES(40), .REVERSAL_TONE_CYCLES(100),
		.RELEASE_CYCLES(40)) dut (.clock, .rst, .cfgWrite, .cfgPreset, .cfgDoubleTalkThreshold,
		.cfgSuppressionThreshold, .cfgSlowField, .cfgProcessorType, .cfgRejectEcho,
		.cfgRejectDoubletalk, .cfgRampScheme, .cfgRampRate, .cfgNoiseScaling, .cfgPathDetect,
		.cfgPathClear, .cfgProcessorDisable, .cfgNoiseInjectDisable, .cfgToneTypeSelect,
		.cfgAutoToneDisable, .hostBypass, .hostAdaptDisable, .irqClear, .recvLevel, .sendLevel,
		.errorLevel, .uncertain, .pathChange, .toneInBand, .toneLevel, .phaseReversal,
		.lowBandLevel, .highBandLevel, .recvInCode, .sendInCode, .cancelledCode, .recvOutCode,
		.sendOutCode, .adaptEnable, .adaptShift, .clearCoeff, .fastConverge, .bypassActive,
		.doubleTalk, .nlpActive, .extraAttenuation, .injectNoise, .comfortLevel, .toneDetected,
		.irqN);
	echo_host_model host (.clock, .rst, .slow(hostSlow), .autoMask(cfgAutoToneDisable), .irqN,
		.toneDetected, .hostBypass, .irqClear);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// inputs move on the falling edge; one receive code keeps changing
	task automatic tick();
		@(negedge clock);
		recvInCode[1] = recvInCode[1] + 8'h01;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// bounded wait: 0 status, 1 bypass, 2 interrupt line
	task automatic waitv(input int sel, input int i, input logic v, input int max, output int k);
		logic s;
		for (k = 0; k < max; k++) begin
			tick();
			s = sel == 0 ? toneDetected[i] : (sel == 1 ? bypassActive[i] : irqN);
			if (s === v) return;
		end
		fails++;
		$display("mismatch at %0t: wait timed out", $time);
		results();
	endtask

	// config lands on the first edge, outputs follow on the second
	task automatic wrcfg();
		cfgWrite = 1'b1;
		tick();
		cfgWrite = 1'b0;
		tick();
	endtask

	task automatic preset(input logic kind);
		{cfgPreset, cfgProcessorType} = {1'b1, kind};
		tick();
		cfgPreset = 1'b0;
		tick();
	endtask

	task automatic test_levels();
		chk({irqN, toneDetected}, 5'h10);
		sendLevel[0] = 8'he8;
		tick();
		chk({doubleTalk[0], adaptEnable[0]}, 2'b10);
		sendLevel[0] = 8'he7;
		tick();
		chk({doubleTalk[0], adaptEnable[0]}, 2'b01);
		cfgDoubleTalkThreshold = 16'h4000;
		wrcfg();
		chk({doubleTalk[0], adaptEnable[0]}, 2'b10);
		cfgDoubleTalkThreshold = 16'h4800;
		uncertain[0] = 1'b1;
		wrcfg();
		chk({adaptShift[0], adaptEnable[0]}, 5'h09);
		{cfgSlowField, hostAdaptDisable[1]} = {3'h0, 1'b1};
		wrcfg();
		chk(adaptEnable[1:0], 2'b00);
		{cfgSlowField, hostAdaptDisable, uncertain, sendLevel[0]} = {3'h4, 8'h00, 8'he6};
		wrcfg();
	endtask

	task automatic test_path();
		pathChange[2] = 1'b1;
		tick();
		chk({fastConverge[2], clearCoeff[2]}, 2'b00);
		cfgPathDetect[2] = 1'b1;
		wrcfg();
		chk({fastConverge[2], clearCoeff[2]}, 2'b10);
		cfgPathClear[2] = 1'b1;
		wrcfg();
		chk({fastConverge[2], clearCoeff[2]}, 2'b11);
		pathChange[2] = 1'b0;
	endtask

	// residual just above and below the suppression level, then comfort noise
	task automatic test_nlp();
		errorLevel[3] = 8'he4;
		tick();
		chk({nlpActive[3], extraAttenuation[3]}, 7'h00);
		errorLevel[3] = 8'hdc;
		tick();
		chk({nlpActive[3], extraAttenuation[3], injectNoise[3]}, 8'hbd);
		cfgNoiseScaling = 8'h00;
		wrcfg();
		c0 = comfortLevel[3];
		cfgNoiseScaling = 8'hf8;
		wrcfg();
		chk($signed(comfortLevel[3]) > $signed(c0), 1'b1);
		preset(1'b0);
		c0 = comfortLevel[3];
		preset(1'b1);
		chk($signed(c0) > $signed(comfortLevel[3]), 1'b1);
		cfgNoiseInjectDisable[3] = 1'b1;
		wrcfg();
		chk({nlpActive[3], injectNoise[3]}, 2'b10);
		cfgProcessorDisable[3] = 1'b1;
		wrcfg();
		chk({nlpActive[3], injectNoise[3]}, 2'b00);
	endtask

	// plain tone on a receive input, host services the interrupt
	task automatic test_plain();
		cfgToneTypeSelect = 4'h1;
		wrcfg();
		{toneInBand[0], toneLevel[0], lowBandLevel[0]} = {1'b1, 8'h00, 8'hf6};
		repeat (30) tick();
		toneInBand[0] = 1'b0;
		tick();
		chk(toneDetected[0], 1'b0);
		toneInBand[0] = 1'b1;
		waitv(0, 0, 1'b1, 60, n);
		chk(n >= 39, 1'b1);
		waitv(2, 0, 1'b0, 3, n);
		waitv(1, 0, 1'b1, 20, n);
		chk({sendOutCode[0], clearCoeff[0]}, {8'h5a, 1'b1});
		{toneInBand[0], lowBandLevel[0], highBandLevel[0]} = {1'b0, 8'he0, 8'hdf};
		repeat (60) tick();
		chk(toneDetected[0], 1'b1);
		highBandLevel[0] = 8'hdd;
		waitv(0, 0, 1'b0, 60, n);
		chk(n >= 39, 1'b1);
		waitv(2, 0, 1'b0, 3, n);
		waitv(1, 0, 1'b0, 30, n);
		chk({sendOutCode[0], clearCoeff[0]}, {8'ha5, 1'b0});
	endtask

	// reversal tone on a send input, automatic bypass, slow host
	task automatic test_reversal();
		{cfgAutoToneDisable, hostSlow} = {4'h2, 1'b1};
		wrcfg();
		{toneInBand[3], toneLevel[3], lowBandLevel[3]} = {1'b1, 8'hfa, 8'hf6};
		repeat (130) tick();
		chk(toneDetected[1], 1'b0);
		toneInBand[3] = 1'b0;
		tick();
		toneInBand[3] = 1'b1;
		repeat (10) tick();
		phaseReversal[3] = 1'b1;
		tick();
		phaseReversal[3] = 1'b0;
		waitv(0, 1, 1'b1, 110, n);
		chk(n >= 88, 1'b1);
		waitv(1, 1, 1'b1, 3, n);
		{toneInBand[3], lowBandLevel[3]} = {1'b0, 8'hc4};
		waitv(0, 1, 1'b0, 60, n);
		waitv(1, 1, 1'b0, 3, n);
	endtask

	initial begin
		{fails, total_checks, rst} = {32'h0, 32'h0, 1'b1};
		{cfgWrite, cfgPreset, hostSlow, cfgRampScheme, cfgProcessorType} = 5'b00011;
		{cfgRejectEcho, cfgRejectDoubletalk, cfgSlowField, cfgRampRate} = {2'b11, 3'h4, 4'h5};
		{cfgDoubleTalkThreshold, cfgSuppressionThreshold} = {16'h4800, 16'h2000};
		{cfgNoiseScaling, toneInBand, phaseReversal} = {8'h16, 16'h0000};
		{cfgPathDetect, cfgPathClear, cfgProcessorDisable, cfgNoiseInjectDisable} = '0;
		{cfgToneTypeSelect, cfgAutoToneDisable, hostAdaptDisable, uncertain, pathChange} = '0;
		{recvLevel, sendLevel, errorLevel} = {{4{8'hec}}, {4{8'hc4}}, {4{8'hc4}}};
		{recvInCode, sendInCode, cancelledCode} = {{4{8'h3c}}, {4{8'h5a}}, {4{8'ha5}}};
		{toneLevel, lowBandLevel, highBandLevel} = {64'h0, {16{8'hc4}}};
		repeat (16) tick();
		rst = 1'b0;
		test_levels();
		test_path();
		test_nlp();
		test_plain();
		test_reversal();
		results();
	end
endmodule
`default_nettype wire
